// ---- logic/gq_pin_mux.sv ----
// Notes on behaviour
// R01: each port pin has two-bit function select; 00 is GPIO and reset value.
// R02: analog field upper bit 0 offers digital line, else converter input only.
// R03: analog field upper bit 1 routes purely analog; reset default.
// R04: A-side fields 5-4, 9-8, 13-12 feed converter and comparator A inputs.
// R05: B-side fields 21-20, 25-24, 29-28 feed converter and comparator B inputs.
// R06: qualifier select 00, reset default, only synchronizes to system clock; here the level also waits for two successive synchronized samples to agree.
// R07: qualifier selects 01 and 10 synchronize then filter over a sample window.
// R08: sample interval set by period field, one per eight pins.
// R09: window is three or six samples; output changes only when all agree.
// R10: qualifier select 11 bypasses synchronization, passing raw pin level.
// R11: unselected peripheral input holds a fixed inactive level.
// R12: one peripheral input may come from several pins; routing resolves them.
// R13: data register write sets output latch; read returns qualified pin level.
// R14: select register writes take effect two clock cycles later.
// R15: software never programs reserved select values; behaviour then undefined.
// R16: select 01 uses three-sample window, 10 uses six-sample window.
// R17: debug pins and top three fields offer no alternative; nonzero is reserved.
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`include "gq_regs.svh"
`default_nettype none
module gq_pin_mux import gq_pkg::*; #(
    parameter int NPIN = 13,
    parameter int NAIO = 6,
    parameter int NCONV = 16,
    parameter int PW = 8,
    parameter int GRP = 8,
    parameter logic [2:0] INACTIVE = 3'h3
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NPIN-1:0] pin_in,
    output logic [NPIN-1:0] pin_out,
    output logic [NPIN-1:0] pin_oe,
    input wire logic [NAIO-1:0] aio_in,
    output logic [NAIO-1:0] aio_out,
    output logic [NAIO-1:0] aio_oe,
    output logic [NCONV-1:0] conv_route,
    output logic [2:0] comp_a_route,
    output logic [2:0] comp_b_route,
    input wire logic i2c_data_pull,
    input wire logic i2c_clk_pull,
    input wire logic pwm_sync_out,
    input wire logic soc_a_out,
    input wire logic soc_b_out,
    input wire logic [2:0] comp_out,
    input wire logic pwm7_a,
    input wire logic pwm7_b,
    input wire logic [2:0] porta_cand_vld,
    input wire logic [2:0] porta_cand_lvl,
    output logic i2c_data_in,
    output logic i2c_clk_in,
    output logic pwm_sync_in
);
    localparam int NGRP = (NPIN + GRP - 1) / GRP;
    localparam int NQ = NPIN + NAIO;

    typedef struct packed {
        logic aw_h;
        logic [7:0] aw_a;
        logic w_h;
        logic [31:0] w_d;
        logic [3:0] w_s;
        logic bv;
        logic [1:0] br;
        logic rv;
        logic [31:0] rd;
        logic [1:0] rr;
        logic [31:0] fsel;
        logic [31:0] amux;
        logic [2*NPIN-1:0] qsel;
        logic [NGRP*PW-1:0] ctrl;
        logic [NPIN-1:0] dat;
        logic [NPIN-1:0] dir;
        logic [NAIO-1:0] alat;
        logic [NAIO-1:0] adir;
        logic [31:0] fsel_d1;
        logic [31:0] fsel_e;
        logic [31:0] amux_d1;
        logic [31:0] amux_e;
        logic [2*NPIN-1:0] qsel_d1;
        logic [2*NPIN-1:0] qsel_e;
        logic [NGRP-1:0][PW-1:0] cnt;
        logic [NPIN-1:0] po;
        logic [NPIN-1:0] poe;
        logic [NAIO-1:0] ao;
        logic [NAIO-1:0] aoe;
        logic [2:0] pin;
    } gq_st_t;
    gq_st_t st_r, st_nxt;

    logic [NQ-1:0] qlvl;
    logic [NGRP-1:0] samp_en;
    logic [NAIO-1:0] aio_up;

    gq_qual_if qif [NQ] ();

    genvar k;
    generate
        for (k = 0; k < NQ; k++) begin : g_q
            if (k < NPIN) begin : g_pin
                assign qif[k].raw = pin_in[k];
                assign qif[k].mode = gq_qmode_t'(st_r.qsel_e[2*k +: 2]);
                assign qif[k].samp_en = samp_en[k / GRP]; // R08
            end else begin : g_aio
                assign qif[k].raw = aio_in[k-NPIN];
                assign qif[k].mode = q_sync;
                assign qif[k].samp_en = 1'b0;
            end
            assign qlvl[k] = qif[k].level;
            gq_qualifier u_q (
                .clk(clk),
                .sys_rst(sys_rst),
                .q(qif[k])
            );
        end
    endgenerate

    function automatic logic [31:0] strb_merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) r[8*b +: 8] = d[8*b +: 8];
        end
        return r;
    endfunction

    function automatic int aio_fld(input int i);
        int f;
        f = (i < 3) ? (`GQ_AIO_A_BASE + `GQ_AIO_STEP * i) : (`GQ_AIO_B_BASE + `GQ_AIO_STEP * (i - 3));
        return f;
    endfunction

    always_comb begin
        for (int g = 0; g < NGRP; g++) begin
            samp_en[g] = (st_r.cnt[g] == '0);
        end
        for (int i = 0; i < NAIO; i++) begin
            aio_up[i] = st_r.amux_e[2*aio_fld(i)+1];
        end
    end

    assign s_axi_awready = !st_r.aw_h && !st_r.bv;
    assign s_axi_wready = !st_r.w_h && !st_r.bv;
    assign s_axi_arready = !st_r.rv;
    assign s_axi_bvalid = st_r.bv;
    assign s_axi_bresp = st_r.br;
    assign s_axi_rvalid = st_r.rv;
    assign s_axi_rdata = st_r.rd;
    assign s_axi_rresp = st_r.rr;
    assign pin_out = st_r.po;
    assign pin_oe = st_r.poe;
    assign aio_out = st_r.ao;
    assign aio_oe = st_r.aoe;
    assign i2c_data_in = st_r.pin[0];
    assign i2c_clk_in = st_r.pin[1];
    assign pwm_sync_in = st_r.pin[2];

    always_comb begin
        conv_route = '1;
        for (int i = 0; i < NAIO; i++) begin
            conv_route[aio_fld(i)] = aio_up[i]; // R02 R03
        end
        comp_a_route = aio_up[2:0]; // R04
        comp_b_route = aio_up[5:3]; // R05
    end

    always_comb begin
        logic have_a;
        logic have_d;
        logic [7:0] wa;
        logic [31:0] m;
        logic [31:0] wd;
        logic [3:0] ws;
        gq_fsel_t sel;
        st_nxt = st_r;
        m = '0;
        sel = fs_gpio;
        // write channel
        have_a = st_r.aw_h || (s_axi_awvalid && s_axi_awready);
        have_d = st_r.w_h || (s_axi_wvalid && s_axi_wready);
        wa = st_r.aw_h ? st_r.aw_a : s_axi_awaddr;
        wd = st_r.w_h ? st_r.w_d : s_axi_wdata;
        ws = st_r.w_h ? st_r.w_s : s_axi_wstrb;
        if (st_r.bv && s_axi_bready) begin
            st_nxt.bv = 1'b0;
        end
        if (have_a && have_d) begin
            st_nxt.aw_h = 1'b0;
            st_nxt.w_h = 1'b0;
            st_nxt.bv = 1'b1;
            st_nxt.br = `GQ_RESP_OK;
            unique case (wa)
                `GQ_OFS_FSEL: st_nxt.fsel = strb_merge(st_r.fsel, wd, ws);
                `GQ_OFS_AMUX: st_nxt.amux = strb_merge(st_r.amux, wd, ws);
                `GQ_OFS_QSEL: begin
                    m = strb_merge(32'(st_r.qsel), wd, ws);
                    st_nxt.qsel = m[2*NPIN-1:0];
                end
                `GQ_OFS_CTRL: begin
                    m = strb_merge(32'(st_r.ctrl), wd, ws);
                    st_nxt.ctrl = m[NGRP*PW-1:0]; // R08
                end
                `GQ_OFS_DAT: begin
                    m = strb_merge(32'(st_r.dat), wd, ws);
                    st_nxt.dat = m[NPIN-1:0]; // R13
                end
                `GQ_OFS_DIR: begin
                    m = strb_merge(32'(st_r.dir), wd, ws);
                    st_nxt.dir = m[NPIN-1:0];
                end
                `GQ_OFS_AIO: begin
                    m = strb_merge((32'(st_r.adir) << `GQ_AIO_DIR_LSB) | 32'(st_r.alat), wd, ws);
                    st_nxt.alat = m[NAIO-1:0];
                    st_nxt.adir = m[`GQ_AIO_DIR_LSB +: NAIO];
                end
                default: st_nxt.br = `GQ_RESP_ERR;
            endcase
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                st_nxt.aw_h = 1'b1;
                st_nxt.aw_a = s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                st_nxt.w_h = 1'b1;
                st_nxt.w_d = s_axi_wdata;
                st_nxt.w_s = s_axi_wstrb;
            end
        end
        // read channel
        if (st_r.rv && s_axi_rready) begin
            st_nxt.rv = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            st_nxt.rv = 1'b1;
            st_nxt.rr = `GQ_RESP_OK;
            st_nxt.rd = '0;
            unique case (s_axi_araddr)
                `GQ_OFS_FSEL: st_nxt.rd = st_r.fsel;
                `GQ_OFS_AMUX: st_nxt.rd = st_r.amux;
                `GQ_OFS_QSEL: st_nxt.rd = 32'(st_r.qsel);
                `GQ_OFS_CTRL: st_nxt.rd = 32'(st_r.ctrl);
                `GQ_OFS_DAT: st_nxt.rd = 32'(qlvl[NPIN-1:0]); // R13
                `GQ_OFS_DIR: st_nxt.rd = 32'(st_r.dir);
                `GQ_OFS_AIO: st_nxt.rd = (32'(st_r.adir) << `GQ_AIO_DIR_LSB) | 32'(qlvl[NQ-1:NPIN]);
                default: st_nxt.rr = `GQ_RESP_ERR;
            endcase
        end
        // delayed select copies
        st_nxt.fsel_d1 = st_r.fsel; // R14
        st_nxt.fsel_e = st_r.fsel_d1; // R14
        st_nxt.amux_d1 = st_r.amux; // R14
        st_nxt.amux_e = st_r.amux_d1; // R14
        st_nxt.qsel_d1 = st_r.qsel; // R14
        st_nxt.qsel_e = st_r.qsel_d1; // R14
        // sample period dividers
        for (int g = 0; g < NGRP; g++) begin
            st_nxt.cnt[g] = samp_en[g] ? st_r.ctrl[g*PW +: PW] : st_r.cnt[g] - 1'b1; // R08
        end
        // pin output routing
        for (int i = 0; i < NPIN; i++) begin
            sel = gq_fsel_t'(st_r.fsel_e[2*i +: 2]);
            st_nxt.po[i] = 1'b0;
            st_nxt.poe[i] = 1'b0;
            unique case (sel)
                fs_gpio: begin
                    st_nxt.po[i] = st_r.dat[i]; // R01
                    st_nxt.poe[i] = st_r.dir[i]; // R01
                end
                fs_alt1: begin
                    if (i == `GQ_PIN_I2C_DATA) st_nxt.poe[i] = i2c_data_pull;
                    if (i == `GQ_PIN_I2C_CLK) st_nxt.poe[i] = i2c_clk_pull;
                    if (i == `GQ_PIN_CMP_MIX) {st_nxt.po[i], st_nxt.poe[i]} = {comp_out[1], 1'b1};
                    if (i == `GQ_PIN_PWM7A) {st_nxt.po[i], st_nxt.poe[i]} = {pwm7_a, 1'b1};
                    if (i == `GQ_PIN_PWM7B) {st_nxt.po[i], st_nxt.poe[i]} = {pwm7_b, 1'b1};
                end
                fs_alt2: begin
                    if (i == `GQ_PIN_I2C_CLK) {st_nxt.po[i], st_nxt.poe[i]} = {pwm_sync_out, 1'b1};
                end
                fs_alt3: begin
                    if (i == `GQ_PIN_I2C_DATA) {st_nxt.po[i], st_nxt.poe[i]} = {soc_a_out, 1'b1};
                    if (i == `GQ_PIN_I2C_CLK) {st_nxt.po[i], st_nxt.poe[i]} = {soc_b_out, 1'b1};
                    if (i == `GQ_PIN_CMP_MIX) {st_nxt.po[i], st_nxt.poe[i]} = {comp_out[2], 1'b1};
                    if (i == `GQ_PIN_CMP1) {st_nxt.po[i], st_nxt.poe[i]} = {comp_out[0], 1'b1};
                    if (i == `GQ_PIN_CMP2) {st_nxt.po[i], st_nxt.poe[i]} = {comp_out[1], 1'b1};
                end
            endcase
            // other combinations stay undriven: R15 R17
        end
        // analog-digital lines
        for (int i = 0; i < NAIO; i++) begin
            st_nxt.ao[i] = st_r.alat[i];
            st_nxt.aoe[i] = st_r.adir[i] && !aio_up[i]; // R02 R03
        end
        // peripheral input resolution, port A candidates first, port B pin last so it wins
        st_nxt.pin = INACTIVE; // R11
        for (int j = 0; j < 3; j++) begin
            if (porta_cand_vld[j]) st_nxt.pin[j] = porta_cand_lvl[j]; // R12
        end
        if (gq_fsel_t'(st_r.fsel_e[2*`GQ_PIN_I2C_DATA +: 2]) == fs_alt1) begin
            st_nxt.pin[0] = qlvl[`GQ_PIN_I2C_DATA]; // R12
        end
        if (gq_fsel_t'(st_r.fsel_e[2*`GQ_PIN_I2C_CLK +: 2]) == fs_alt1) begin
            st_nxt.pin[1] = qlvl[`GQ_PIN_I2C_CLK]; // R12
        end
        if (gq_fsel_t'(st_r.fsel_e[2*`GQ_PIN_I2C_DATA +: 2]) == fs_alt2) begin
            st_nxt.pin[2] = qlvl[`GQ_PIN_I2C_DATA]; // R12
        end
        if (sys_rst) begin
            st_nxt = '0;
            st_nxt.fsel = `GQ_RST_FSEL; // R01
            st_nxt.fsel_d1 = `GQ_RST_FSEL;
            st_nxt.fsel_e = `GQ_RST_FSEL;
            st_nxt.amux = `GQ_RST_AMUX; // R03
            st_nxt.amux_d1 = `GQ_RST_AMUX;
            st_nxt.amux_e = `GQ_RST_AMUX;
            st_nxt.qsel = (2*NPIN)'(`GQ_RST_QSEL); // R06
            st_nxt.qsel_d1 = (2*NPIN)'(`GQ_RST_QSEL);
            st_nxt.qsel_e = (2*NPIN)'(`GQ_RST_QSEL);
            st_nxt.ctrl = (NGRP*PW)'(`GQ_RST_CTRL);
            st_nxt.pin = INACTIVE;
        end
    end

    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end
endmodule
`default_nettype wire

// ---- common/gq_regs.svh ----
`ifndef GQ_REGS_SVH
`define GQ_REGS_SVH
`define GQ_OFS_FSEL 8'h00
`define GQ_OFS_AMUX 8'h04
`define GQ_OFS_QSEL 8'h08
`define GQ_OFS_CTRL 8'h0C
`define GQ_OFS_DAT 8'h10
`define GQ_OFS_DIR 8'h14
`define GQ_OFS_AIO 8'h18
`define GQ_RST_FSEL 32'h0000_0000
`define GQ_RST_AMUX 32'hAAAA_AAAA
`define GQ_RST_QSEL 32'h0000_0000
`define GQ_RST_CTRL 32'h0000_0000
`define GQ_RESP_OK 2'h0
`define GQ_RESP_ERR 2'h2
`define GQ_AIO_DIR_LSB 16
`define GQ_AIO_A_BASE 2
`define GQ_AIO_B_BASE 10
`define GQ_AIO_STEP 2
`define GQ_PIN_I2C_DATA 0
`define GQ_PIN_I2C_CLK 1
`define GQ_PIN_CMP_MIX 2
`define GQ_PIN_PWM7A 8
`define GQ_PIN_PWM7B 9
`define GQ_PIN_CMP1 10
`define GQ_PIN_CMP2 11
`define GQ_WIN3_LEN 3
`define GQ_WIN6_LEN 6
`endif

// ---- common/gq_pkg.sv ----
`default_nettype none
package gq_pkg;
    typedef enum logic [1:0] {q_sync, q_win3, q_win6, q_raw} gq_qmode_t;
    typedef enum logic [1:0] {fs_gpio, fs_alt1, fs_alt2, fs_alt3} gq_fsel_t;
endpackage
`default_nettype wire

// ---- common/gq_qual_if.sv ----
`default_nettype none
interface gq_qual_if import gq_pkg::*; ();
    logic raw;
    gq_qmode_t mode;
    logic samp_en;
    logic level;
    modport ctl (output raw, output mode, output samp_en, input level);
    modport qual (input raw, input mode, input samp_en, output level);
endinterface
`default_nettype wire

// ---- logic/gq_qualifier.sv ----
`include "gq_regs.svh"
`default_nettype none
module gq_qualifier import gq_pkg::*; (
    input wire logic clk,
    input wire logic sys_rst,
    gq_qual_if.qual q
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic [`GQ_WIN6_LEN-1:0] win;
        logic lvl;
    } gq_qst_t;
    gq_qst_t st_r, st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = q.raw;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        if (q.samp_en) begin
            st_nxt.win = {st_r.win[`GQ_WIN6_LEN-2:0], st_r.s3};
        end
        unique case (q.mode)
            q_sync: if (st_r.s2 == st_r.s3) st_nxt.lvl = st_r.s3; // R06
            q_win3: begin
                if (st_nxt.win[`GQ_WIN3_LEN-1:0] == '0) st_nxt.lvl = 1'b0; // R07 R09 R16
                if (st_nxt.win[`GQ_WIN3_LEN-1:0] == '1) st_nxt.lvl = 1'b1; // R09
            end
            q_win6: begin
                if (st_nxt.win == '0) st_nxt.lvl = 1'b0; // R07 R09 R16
                if (st_nxt.win == '1) st_nxt.lvl = 1'b1; // R09
            end
            q_raw: st_nxt.lvl = st_r.lvl;
        endcase
        if (sys_rst) begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    assign q.level = (q.mode == q_raw) ? q.raw : st_r.lvl; // R10
endmodule
`default_nettype wire

// ---- testbench/gq_pin_mux_properties.sv ----
`default_nettype none
module gq_pin_mux_chk #(
    parameter int NPIN = 13,
    parameter int NCONV = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NPIN-1:0] pin_oe,
    input wire logic [NCONV-1:0] conv_route,
    input wire logic [2:0] comp_a_route,
    input wire logic [2:0] comp_b_route,
    input wire logic i2c_data_in,
    input wire logic i2c_clk_in,
    input wire logic pwm_sync_in
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_reset_gpio: assert property (disable iff (1'h0) sys_rst |=> pin_oe == '0)
        else $error("pin driven after reset");
    a_reset_analog: assert property (disable iff (1'h0) sys_rst |=> &conv_route && &comp_a_route)
        else $error("analog default missing");
    a_plain_conv: assert property ((conv_route[15:0] & 16'hABAB) == 16'hABAB)
        else $error("plain converter input dropped");
    a_comp_a_pair: assert property (comp_a_route == {conv_route[6], conv_route[4], conv_route[2]})
        else $error("comparator a route apart from converter");
    a_comp_b_pair: assert property (comp_b_route == {conv_route[14], conv_route[12], conv_route[10]})
        else $error("comparator b route apart from converter");
    a_inactive_inputs: assert property (disable iff (1'h0) sys_rst |=> i2c_data_in && i2c_clk_in && !pwm_sync_in)
        else $error("idle peripheral input level");
    a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data moved");
    a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property ($fell(comp_a_route[0]));
endmodule
`default_nettype wire

// ---- testbench/gq_far_side.sv ----
`default_nettype none
module gq_far_side #(
    parameter int NPIN = 13
) (
    input wire logic clk,
    input wire logic [9:0] ctl,
    input wire logic [NPIN-1:0] ext_pin,
    input wire logic [NPIN-1:0] pin_out,
    input wire logic [NPIN-1:0] pin_oe,
    input wire logic [5:0] ext_aio,
    input wire logic [5:0] aio_out,
    input wire logic [5:0] aio_oe,
    output logic [NPIN-1:0] pin_in,
    output logic [5:0] aio_in,
    output logic [9:0] periph
);
    timeunit 1ns;
    timeprecision 100ps;
    // peripherals launch off the same clock
    always_ff @(posedge clk) periph <= ctl;
    // a driven pad follows its driver, else the board level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_pin);
    assign aio_in = (aio_oe & aio_out) | (~aio_oe & ext_aio);
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
`include "gq_regs.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'h0, sys_rst = 1'h1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [2:0] porta_cand_vld = 3'h0, porta_cand_lvl = 3'h0, comp_a_route, comp_b_route;
    logic [9:0] ctl = 10'h000, periph;
    logic [12:0] ext_pin = 13'h0000, pin_in, pin_out, pin_oe;
    logic [5:0] ext_aio = 6'h00, aio_in, aio_out, aio_oe;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic i2c_data_in, i2c_clk_in, pwm_sync_in;
    logic [1:0] s_axi_bresp, s_axi_rresp, r, b;
    logic [15:0] conv_route;
    int err_count = 0, tests_run = 0, cyc = 0;
    gq_pin_mux gq_pin_mux_inst (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in,
        .pin_out, .pin_oe, .aio_in, .aio_out, .aio_oe, .conv_route, .comp_a_route, .comp_b_route,
        .i2c_data_pull(periph[0]), .i2c_clk_pull(periph[1]), .pwm_sync_out(periph[2]), .soc_a_out(periph[3]),
        .soc_b_out(periph[4]), .comp_out(periph[7:5]), .pwm7_a(periph[8]), .pwm7_b(periph[9]),
        .porta_cand_vld, .porta_cand_lvl, .i2c_data_in, .i2c_clk_in, .pwm_sync_in);
    gq_far_side gq_far_side_inst (.clk, .ctl, .ext_pin, .pin_out, .pin_oe, .ext_aio, .aio_out, .aio_oe,
        .pin_in, .aio_in, .periph);
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish;
        if (err_count == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic aw_ok, w_ok, bv, b_ok;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(negedge clk);
            aw_ok = s_axi_awready;
            w_ok = s_axi_wready;
            bv = s_axi_bvalid;
            b_ok = bv && s_axi_bready;
            b = s_axi_bresp;
            @(posedge clk);
            if (aw_ok) s_axi_awvalid <= 1'h0;
            if (w_ok) s_axi_wvalid <= 1'h0;
            // late ready makes the response wait one cycle
            s_axi_bready <= bv && !b_ok;
        end while (!b_ok);
    endtask
    task automatic rd(input logic [7:0] a);
        logic ok, v, rv;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do begin
            @(negedge clk);
            ok = s_axi_arready;
            v = s_axi_rvalid;
            rv = v && s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
            if (ok) s_axi_arvalid <= 1'h0;
            s_axi_rready <= v && !rv;
        end while (!rv);
    endtask
    task automatic t_reset_regs;
        logic [7:0] ad [4] = '{`GQ_OFS_FSEL, `GQ_OFS_AMUX, `GQ_OFS_QSEL, `GQ_OFS_CTRL};
        logic [31:0] ex [4] = '{32'h0, 32'hAAAA_AAAA, 32'h0, 32'h0};
        for (int i = 0; i < 4; i++) begin
            rd(ad[i]);
            chk(d, ex[i]);
        end
        rd(8'h1C);
        chk(r, 2'h2);
        wr(8'h1C, 32'h0);
        chk(b, 2'h2);
    endtask
    task automatic t_func;
        logic [1:0] e [4] = '{2'h2, 2'h0, 2'h2, 2'h3};
        ctl <= 10'h110;
        wr(`GQ_OFS_DIR, 32'h2);
        chk(b, 2'h0);
        wr(`GQ_OFS_DAT, 32'h0);
        for (int c = 0; c < 4; c++) begin
            wr(`GQ_OFS_FSEL, 32'(c) << 2);
            repeat (3) @(posedge clk);
            #1 chk({pin_oe[1], pin_out[1]}, e[c]);
        end
        wr(`GQ_OFS_FSEL, 32'h0001_0000);
        // write was taken two edges before return
        #1 chk(pin_oe[8], 1'h0);
        @(posedge clk);
        #1 chk({pin_oe[8], pin_out[8]}, 2'h3);
        wr(`GQ_OFS_FSEL, 32'h0);
    endtask
    task automatic t_analog;
        wr(`GQ_OFS_AMUX, 32'hAA8A_AA8A);
        wr(`GQ_OFS_AIO, 32'h0001_0001);
        repeat (3) @(posedge clk);
        #1 chk({comp_b_route, comp_a_route}, 6'h36);
        chk(conv_route, 16'hFBFB);
        chk({aio_oe[0], aio_out[0]}, 2'h3);
        wr(`GQ_OFS_AMUX, 32'hAAAA_AAAA);
        repeat (3) @(posedge clk);
        #1 chk({aio_oe[0], conv_route}, 17'h0FFFF);
        chk({comp_b_route, comp_a_route}, 6'h3F);
    endtask
    task automatic t_data;
        wr(`GQ_OFS_DIR, 32'h0);
        wr(`GQ_OFS_DAT, 32'h1FFF);
        rd(`GQ_OFS_DAT);
        chk(d, 32'h0);
        wr(`GQ_OFS_QSEL, 32'h3000);
        ext_pin <= 13'h00C0;
        rd(`GQ_OFS_DAT);
        chk(d, 32'h40);
        repeat (6) @(posedge clk);
        rd(`GQ_OFS_DAT);
        chk(d, 32'hC0);
    endtask
    task automatic t_window;
        wr(`GQ_OFS_CTRL, 32'h2);
        wr(`GQ_OFS_QSEL, 32'h0900);
        ext_pin <= 13'h0030;
        repeat (40) @(posedge clk);
        ext_pin <= 13'h0000;
        @(posedge clk);
        ext_pin <= 13'h0030;
        repeat (30) @(posedge clk);
        rd(`GQ_OFS_DAT);
        chk(d[5:4], 2'h3);
        ext_pin <= 13'h0000;
        repeat (12) @(posedge clk);
        rd(`GQ_OFS_DAT);
        chk(d[5:4], 2'h2);
        repeat (30) @(posedge clk);
        rd(`GQ_OFS_DAT);
        chk(d[5:4], 2'h0);
        wr(`GQ_OFS_QSEL, 32'h0);
    endtask
    task automatic t_route;
        porta_cand_vld <= 3'h4;
        porta_cand_lvl <= 3'h4;
        repeat (3) @(posedge clk);
        #1 chk(pwm_sync_in, 1'h1);
        wr(`GQ_OFS_FSEL, 32'h2);
        repeat (8) @(posedge clk);
        #1 chk(pwm_sync_in, 1'h0);
        wr(`GQ_OFS_FSEL, 32'h0);
        repeat (4) @(posedge clk);
        #1 chk(pwm_sync_in, 1'h1);
        @(posedge clk);
        porta_cand_vld <= 3'h0;
        repeat (3) @(posedge clk);
        #1 chk({i2c_clk_in, i2c_data_in, pwm_sync_in}, 3'h6);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'h0;
        t_reset_regs();
        t_func();
        t_analog();
        t_data();
        t_window();
        t_route();
        tally_and_finish();
    end
endmodule
bind gq_pin_mux gq_pin_mux_chk #(.NPIN(NPIN), .NCONV(NCONV)) gq_pin_mux_chk_inst (.clk, .sys_rst, .s_axi_awready,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .pin_oe, .conv_route, .comp_a_route, .comp_b_route, .i2c_data_in,
    .i2c_clk_in, .pwm_sync_in);
`default_nettype wire
